// ---- shared/rmst_consts.svh ----
`ifndef RMST_CONSTS_SVH
`define RMST_CONSTS_SVH

// Register byte offsets
`define RMST_OFF_CTRL        12'h000
`define RMST_OFF_STATUS      12'h004
`define RMST_OFF_BUCK_OV     12'h008
`define RMST_OFF_LIN_OV      12'h00C
`define RMST_OFF_BUCK_UV     12'h010
`define RMST_OFF_LIN_UV      12'h014
`define RMST_OFF_SECURE_KEY  12'h018
`define RMST_OFF_IRQ_MASK    12'h01C

// Control register fields
`define RMST_CTRL_RUN_BIT    0
`define RMST_CTRL_BYPASS_BIT 1
`define RMST_CTRL_SECURE_BIT 2

// Status register fields
`define RMST_STAT_REF_BIT    0
`define RMST_STAT_IRQ_BIT    1
`define RMST_STAT_BUSY_BIT   2
`define RMST_STAT_BLOCK_BIT  3
`define RMST_STAT_SHUT_BIT   4
`define RMST_STAT_PUDONE_BIT 5

// Regulator counts
`define RMST_N_BUCK          5
`define RMST_N_LIN           2

// Secure write key
`define RMST_SECURE_KEY      32'h0000A5C3

// Reset values
`define RMST_CTRL_RST        32'h00000000
`define RMST_MASK_RST        1'b0

// Timing: blanking ceiling and per-phase toggle wait
`define RMST_BLANK_MAX_NS    200000
`define RMST_CLK_PERIOD_NS   5
`define RMST_BLANK_CYC       (`RMST_BLANK_MAX_NS / `RMST_CLK_PERIOD_NS)
`define RMST_TOGGLE_WAIT     16

`endif

// ---- shared/rmst_pkg.sv ----
package rmst_pkg;
  // Self-test sequencer phases
  typedef enum logic [2:0] {
    RMST_IDLE,
    RMST_FORCE_OV,
    RMST_FORCE_UV,
    RMST_RELEASE,
    RMST_DONE
  } rmst_state_t;

  typedef logic [4:0] rmst_buck_t;
  typedef logic [1:0] rmst_lin_t;
endpackage

// ---- verilog/rmst_sync.sv ----
`timescale 1ns/100ps
// Two-flop synchroniser, one per bit
module rmst_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ---- verilog/rmst_apb.sv ----
`timescale 1ns/100ps
`include "rmst_consts.svh"
// APB slave front end: one-wait answer, decodes into strobes
module rmst_apb (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] rdata_in,
  input  wire logic        rd_err,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic             wr_stb,
  output logic [11:0]      wr_addr,
  output logic [31:0]      wr_data
);
  // Access phase is answered one cycle after it opens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      wr_stb  <= 1'b0;
      wr_addr <= 12'h000;
      wr_data <= 32'h00000000;
    end else begin
      wr_stb  <= 1'b0;
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        pslverr <= rd_err;
        prdata  <= pwrite ? 32'h00000000 : rdata_in;
        wr_stb  <= pwrite && !rd_err;
        wr_addr <= paddr;
        wr_data <= pwdata;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end
endmodule

// ---- verilog/rmst_top.sv ----
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "rmst_consts.svh"
// Overview of operation
// - Reference mismatch of 4 to 12 percent is critical, blocks switcher power-up.
// - Safety variant: mismatch at power-up fails self-test and blocks, ignoring bypass.
// - Drift while on with bypass 0 shuts regulator power stages down.
// - Drift while on with bypass 1 only raises the interrupt flag.
// - Reference-fault flag is set on failure unless masked.
// - Status bit is 0 while references agree, 1 while out of range.
// - Self-test exercises each buck and linear overvoltage comparator.
// - Self-test exercises each buck and linear undervoltage comparator.
// - A comparator that fails to toggle sets its readable warning bit.
// - Failure bits live in four groups, one bit per regulator.
// - Every result register is overwritten on each self-test run.
// - With secure writes on, results clear only via secure write.
// - After power-up self-test, sequence continues and results stay readable.
// - Writing 1 to run starts a test; bit self-clears when done.
// - With secure writes on, plain writes cannot start a test.
// - On-demand test blanks fault reporting no longer than 200 us.
// - A monitor failing on-demand sets its own failure flag.
module rmst_top (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic [31:0]               prdata,
  input  wire logic                 ref_mismatch,
  input  wire logic                 safety_variant,
  input  wire logic                 power_up_req,
  input  wire rmst_pkg::rmst_buck_t buck_ov_cmp,
  input  wire rmst_pkg::rmst_buck_t buck_uv_cmp,
  input  wire rmst_pkg::rmst_lin_t  lin_ov_cmp,
  input  wire rmst_pkg::rmst_lin_t  lin_uv_cmp,
  output rmst_pkg::rmst_buck_t      buck_ov_force,
  output rmst_pkg::rmst_buck_t      buck_uv_force,
  output rmst_pkg::rmst_lin_t       lin_ov_force,
  output rmst_pkg::rmst_lin_t       lin_uv_force,
  output logic                      fault_blank,
  output logic                      switcher_enable,
  output logic                      power_stage_shutdown,
  output logic                      reference_fault_irq_flag
);
  import rmst_pkg::*;

  localparam int TOG_W = 5;
  localparam int BLK_W = 16;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic                ref_mis_s;
  logic                safety_s;
  logic                pwrup_s;
  rmst_buck_t          bov_s;
  rmst_buck_t          buv_s;
  rmst_lin_t           lov_s;
  rmst_lin_t           luv_s;

  rmst_sync #(.W(17)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({ref_mismatch, safety_variant, power_up_req,
                buck_ov_cmp, buck_uv_cmp, lin_ov_cmp, lin_uv_cmp}),
    .q       ({ref_mis_s, safety_s, pwrup_s, bov_s, buv_s, lov_s, luv_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // Register bus
  logic                wr_stb;
  logic [11:0]         wr_addr;
  logic [31:0]         wr_data;
  logic [31:0]         rdata;
  logic                addr_bad;

  rmst_apb u_apb (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .rdata_in (rdata),
    .rd_err   (addr_bad),
    .pready   (pready),
    .pslverr  (pslverr),
    .prdata   (prdata),
    .wr_stb   (wr_stb),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data)
  );

  logic                bypass_q;
  logic                secure_en_q;
  logic                irq_mask_q;
  logic                unlock_q;
  logic                run_q;
  rmst_state_t         state_q;
  logic [TOG_W-1:0]    tog_cnt_q;
  logic [BLK_W-1:0]    blk_cnt_q;
  logic                on_demand_q;
  logic                powered_q;
  logic                pu_done_q;
  logic                block_q;
  rmst_buck_t          res_bov_q;
  rmst_buck_t          res_buv_q;
  rmst_lin_t           res_lov_q;
  rmst_lin_t           res_luv_q;
  logic                wr_ctrl;
  logic                wr_res;
  logic                allow;
  logic                start_req;
  logic                test_end;
  logic                ref_on_fault;

  // Plain writes to protected fields pass only after a key write
  assign wr_ctrl = wr_stb && (wr_addr == `RMST_OFF_CTRL);
  assign wr_res  = wr_stb && (wr_addr >= `RMST_OFF_BUCK_OV) && (wr_addr <= `RMST_OFF_LIN_UV);
  assign allow   = !secure_en_q || unlock_q;
  assign start_req = wr_ctrl && wr_data[`RMST_CTRL_RUN_BIT] && allow
                     && (state_q == RMST_IDLE) && pu_done_q;
  assign test_end  = (state_q == RMST_DONE);

  always_comb begin
    addr_bad = 1'b0;
    case (paddr)
      `RMST_OFF_CTRL:       rdata = {29'h0, secure_en_q, bypass_q, run_q};
      `RMST_OFF_STATUS:     rdata = {26'h0, pu_done_q, power_stage_shutdown, block_q,
                                     state_q != RMST_IDLE, reference_fault_irq_flag, ref_mis_s};
      `RMST_OFF_BUCK_OV:    rdata = {27'h0, res_bov_q};
      `RMST_OFF_LIN_OV:     rdata = {30'h0, res_lov_q};
      `RMST_OFF_BUCK_UV:    rdata = {27'h0, res_buv_q};
      `RMST_OFF_LIN_UV:     rdata = {30'h0, res_luv_q};
      `RMST_OFF_SECURE_KEY: rdata = {31'h0, unlock_q};
      `RMST_OFF_IRQ_MASK:   rdata = {31'h0, irq_mask_q};
      default: begin
        rdata    = 32'h00000000;
        addr_bad = 1'b1;
      end
    endcase
  end

  // Configuration bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bypass_q    <= 1'b0;
      secure_en_q <= 1'b0;
      irq_mask_q  <= `RMST_MASK_RST;
    end else begin
      if (wr_ctrl && allow) begin
        bypass_q    <= wr_data[`RMST_CTRL_BYPASS_BIT];
        secure_en_q <= wr_data[`RMST_CTRL_SECURE_BIT];
      end
      if (wr_stb && wr_addr == `RMST_OFF_IRQ_MASK)
        irq_mask_q <= wr_data[0];
    end
  end

  // Key arms only the very next write, whatever register that write targets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_q <= 1'b0;
    end else if (wr_stb) begin
      unlock_q <= (wr_addr == `RMST_OFF_SECURE_KEY) && (wr_data == `RMST_SECURE_KEY);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Self-test sequencer
  // Power-up test runs once; on-demand test starts from the run bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= RMST_IDLE;
      tog_cnt_q   <= '0;
      on_demand_q <= 1'b0;
      run_q       <= 1'b0;
      pu_done_q   <= 1'b0;
    end else begin
      case (state_q)
        RMST_IDLE: begin
          tog_cnt_q <= '0;
          if (pwrup_s && !pu_done_q) begin
            state_q     <= RMST_FORCE_OV;
            on_demand_q <= 1'b0;
          end else if (start_req) begin
            state_q     <= RMST_FORCE_OV;
            on_demand_q <= 1'b1;
            run_q       <= 1'b1;
          end
        end
        RMST_FORCE_OV, RMST_FORCE_UV, RMST_RELEASE: begin
          tog_cnt_q <= tog_cnt_q + TOG_W'(1);
          if (tog_cnt_q == TOG_W'(`RMST_TOGGLE_WAIT)) begin
            tog_cnt_q <= '0;
            state_q   <= (state_q == RMST_FORCE_OV) ? RMST_FORCE_UV :
                         (state_q == RMST_FORCE_UV) ? RMST_RELEASE : RMST_DONE;
          end
        end
        RMST_DONE: begin
          state_q   <= RMST_IDLE;
          run_q     <= 1'b0;
          pu_done_q <= 1'b1;
        end
        default: state_q <= RMST_IDLE;
      endcase
    end
  end

  // Force every comparator of every regulator: all OV ones at once, then all UV ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buck_ov_force <= '0;
      lin_ov_force  <= '0;
      buck_uv_force <= '0;
      lin_uv_force  <= '0;
    end else begin
      buck_ov_force <= {`RMST_N_BUCK{state_q == RMST_FORCE_OV}};
      lin_ov_force  <= {`RMST_N_LIN{state_q == RMST_FORCE_OV}};
      buck_uv_force <= {`RMST_N_BUCK{state_q == RMST_FORCE_UV}};
      lin_uv_force  <= {`RMST_N_LIN{state_q == RMST_FORCE_UV}};
    end
  end

  // Results: cleared at start, failure latched at end of each force window
  genvar gi;
  generate
    for (gi = 0; gi < `RMST_N_BUCK; gi++) begin : g_buck
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          res_bov_q[gi] <= 1'b0;
          res_buv_q[gi] <= 1'b0;
        end else if (state_q == RMST_IDLE && (start_req || (pwrup_s && !pu_done_q))) begin
          res_bov_q[gi] <= 1'b0;
          res_buv_q[gi] <= 1'b0;
        end else if (state_q == RMST_FORCE_OV && tog_cnt_q == TOG_W'(`RMST_TOGGLE_WAIT)) begin
          res_bov_q[gi] <= !bov_s[gi];
        end else if (state_q == RMST_FORCE_UV && tog_cnt_q == TOG_W'(`RMST_TOGGLE_WAIT)) begin
          res_buv_q[gi] <= !buv_s[gi];
        end else if (wr_res && allow && state_q == RMST_IDLE) begin
          if (wr_addr == `RMST_OFF_BUCK_OV) res_bov_q[gi] <= res_bov_q[gi] & wr_data[gi];
          if (wr_addr == `RMST_OFF_BUCK_UV) res_buv_q[gi] <= res_buv_q[gi] & wr_data[gi];
        end
      end
    end
    for (gi = 0; gi < `RMST_N_LIN; gi++) begin : g_lin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          res_lov_q[gi] <= 1'b0;
          res_luv_q[gi] <= 1'b0;
        end else if (state_q == RMST_IDLE && (start_req || (pwrup_s && !pu_done_q))) begin
          res_lov_q[gi] <= 1'b0;
          res_luv_q[gi] <= 1'b0;
        end else if (state_q == RMST_FORCE_OV && tog_cnt_q == TOG_W'(`RMST_TOGGLE_WAIT)) begin
          res_lov_q[gi] <= !lov_s[gi];
        end else if (state_q == RMST_FORCE_UV && tog_cnt_q == TOG_W'(`RMST_TOGGLE_WAIT)) begin
          res_luv_q[gi] <= !luv_s[gi];
        end else if (wr_res && allow && state_q == RMST_IDLE) begin
          if (wr_addr == `RMST_OFF_LIN_OV) res_lov_q[gi] <= res_lov_q[gi] & wr_data[gi];
          if (wr_addr == `RMST_OFF_LIN_UV) res_luv_q[gi] <= res_luv_q[gi] & wr_data[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Blanking during on-demand test, with hard ceiling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_blank <= 1'b0;
      blk_cnt_q   <= '0;
    end else if (state_q != RMST_IDLE && state_q != RMST_DONE && on_demand_q
                 && blk_cnt_q < BLK_W'(`RMST_BLANK_CYC - 1)) begin
      fault_blank <= 1'b1;
      blk_cnt_q   <= blk_cnt_q + BLK_W'(1);
    end else begin
      fault_blank <= 1'b0;
      if (state_q == RMST_IDLE)
        blk_cnt_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference monitor reactions
  // Mismatch while powered counts only outside the power-up window
  assign ref_on_fault = ref_mis_s && powered_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_q              <= 1'b0;
      powered_q            <= 1'b0;
      switcher_enable      <= 1'b0;
      power_stage_shutdown <= 1'b0;
    end else begin
      // Blocking is sticky until reset: a critical fault
      if (ref_mis_s && !powered_q && state_q != RMST_IDLE && safety_s)
        block_q <= 1'b1;
      else if (ref_mis_s && !powered_q)
        block_q <= 1'b1;
      if (pu_done_q && !block_q && !ref_mis_s)
        powered_q <= 1'b1;
      if (ref_on_fault && !bypass_q)
        power_stage_shutdown <= 1'b1;
      switcher_enable <= powered_q && !block_q && !power_stage_shutdown
                         && !(ref_on_fault && !bypass_q);
    end
  end

  // Sticky flag; set beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_fault_irq_flag <= 1'b0;
    end else if (ref_mis_s && !irq_mask_q && !fault_blank) begin
      reference_fault_irq_flag <= 1'b1;
    end else if (wr_stb && wr_addr == `RMST_OFF_STATUS && wr_data[`RMST_STAT_IRQ_BIT]) begin
      reference_fault_irq_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Status read must carry the synchronised mismatch level of the sampling cycle
  property p_status_tracks;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready && !pwrite && paddr == `RMST_OFF_STATUS)
        |=> (prdata[`RMST_STAT_REF_BIT] == $past(ref_mis_s));
  endproperty
  a_status_tracks: assert property (p_status_tracks) else $error("status bit wrong");

  property p_run_clears;
    @(posedge pclk) disable iff (!presetn)
      test_end |=> !run_q && !fault_blank;
  endproperty
  a_run_clears: assert property (p_run_clears) else $error("run bit not cleared");

  property p_blank_limit;
    @(posedge pclk) disable iff (!presetn)
      fault_blank |-> blk_cnt_q <= BLK_W'(`RMST_BLANK_CYC);
  endproperty
  a_blank_limit: assert property (p_blank_limit) else $error("blank too long");

  property p_secure_start;
    @(posedge pclk) disable iff (!presetn)
      $rose(run_q) |-> $past(allow);
  endproperty
  a_secure_start: assert property (p_secure_start) else $error("unsecured start");

  property p_shutdown;
    @(posedge pclk) disable iff (!presetn)
      (ref_on_fault && !bypass_q) |=> power_stage_shutdown;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("no shutdown");

  property p_bypass_keeps;
    @(posedge pclk) disable iff (!presetn)
      (bypass_q && $stable(bypass_q) && !power_stage_shutdown) |=> !power_stage_shutdown;
  endproperty
  a_bypass_keeps: assert property (p_bypass_keeps) else $error("bypass shut down");

  property p_irq_set;
    @(posedge pclk) disable iff (!presetn)
      (ref_mis_s && !irq_mask_q && !fault_blank) |=> reference_fault_irq_flag;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq flag missing");

  property p_ov_force;
    @(posedge pclk) disable iff (!presetn)
      (state_q == RMST_FORCE_OV && tog_cnt_q == 5'h01) |-> (&buck_ov_force) && (&lin_ov_force);
  endproperty
  a_ov_force: assert property (p_ov_force) else $error("ov not forced");

  property p_uv_force;
    @(posedge pclk) disable iff (!presetn)
      (state_q == RMST_FORCE_UV && tog_cnt_q == 5'h01) |-> (&buck_uv_force) && (&lin_uv_force);
  endproperty
  a_uv_force: assert property (p_uv_force) else $error("uv not forced");

  property p_block;
    @(posedge pclk) disable iff (!presetn)
      block_q |=> !switcher_enable;
  endproperty
  a_block: assert property (p_block) else $error("switchers on while blocked");
endmodule

// ---- verif/rmst_cmp_model.sv ----
`timescale 1ns/100ps
// Comparator bank of the regulators; a stuck bit never trips
module rmst_cmp_model (
  input  wire rmst_pkg::rmst_buck_t buck_ov_force,
  input  wire rmst_pkg::rmst_buck_t buck_uv_force,
  input  wire rmst_pkg::rmst_lin_t  lin_ov_force,
  input  wire rmst_pkg::rmst_lin_t  lin_uv_force,
  input  wire rmst_pkg::rmst_buck_t bo_stuck,
  input  wire rmst_pkg::rmst_buck_t bu_stuck,
  input  wire rmst_pkg::rmst_lin_t  lo_stuck,
  input  wire rmst_pkg::rmst_lin_t  lu_stuck,
  output rmst_pkg::rmst_buck_t      buck_ov_cmp,
  output rmst_pkg::rmst_buck_t      buck_uv_cmp,
  output rmst_pkg::rmst_lin_t       lin_ov_cmp,
  output rmst_pkg::rmst_lin_t       lin_uv_cmp
);
  import rmst_pkg::*;
  // Healthy supplies: trips only while forced, so a stuck bit shows as no toggle
  assign buck_ov_cmp = buck_ov_force & ~bo_stuck;
  assign lin_ov_cmp  = lin_ov_force & ~lo_stuck;
  assign buck_uv_cmp = buck_uv_force & ~bu_stuck;
  assign lin_uv_cmp  = lin_uv_force & ~lu_stuck;
endmodule

// ---- verif/tb_rmst_top.sv ----
`timescale 1ns/100ps
`include "rmst_consts.svh"
module tb_rmst_top;
  import rmst_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic        err, ref_mismatch = 0, safety_variant = 0, power_up_req = 0;
  rmst_buck_t  bo_stuck = 0, bu_stuck = 0, bof, buf_f, boc, buc;
  rmst_lin_t   lo_stuck = 0, lu_stuck = 0, lof, luf, loc, luc;
  logic        pready, pslverr, blank, sw_en, shut, irq;
  logic [31:0] prdata;
  int          mismatches = 0, num_checks = 0;

  always #2.5 pclk = ~pclk;

  rmst_top i_rmst_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .ref_mismatch(ref_mismatch), .safety_variant(safety_variant),
    .power_up_req(power_up_req), .buck_ov_cmp(boc), .buck_uv_cmp(buc), .lin_ov_cmp(loc),
    .lin_uv_cmp(luc), .buck_ov_force(bof), .buck_uv_force(buf_f), .lin_ov_force(lof),
    .lin_uv_force(luf), .fault_blank(blank), .switcher_enable(sw_en),
    .power_stage_shutdown(shut), .reference_fault_irq_flag(irq));
  rmst_cmp_model i_rmst_cmp_model (.buck_ov_force(bof), .buck_uv_force(buf_f),
    .lin_ov_force(lof), .lin_uv_force(luf), .bo_stuck(bo_stuck), .bu_stuck(bu_stuck),
    .lo_stuck(lo_stuck), .lu_stuck(lu_stuck), .buck_ov_cmp(boc), .buck_uv_cmp(buc),
    .lin_ov_cmp(loc), .lin_uv_cmp(luc));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, in one place only
  task end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Setup, then access held until pready is sampled high at a rising edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    apb(0, a, 0);
    chk(rd & m, e, s);
  endtask

  // Results of all four groups against the stuck masks
  task res_chk(input logic [31:0] bo, lo, bu, lu);
    rdchk(`RMST_OFF_BUCK_OV, 32'h1F, bo, "buck ov res");
    rdchk(`RMST_OFF_LIN_OV, 32'h03, lo, "lin ov res");
    rdchk(`RMST_OFF_BUCK_UV, 32'h1F, bu, "buck uv res");
    rdchk(`RMST_OFF_LIN_UV, 32'h03, lu, "lin uv res");
  endtask

  // Bounded wait for blanking to start and end; returns blanked cycles
  task run_wait(output int n);
    int k;
    k = 0;
    n = 0;
    while (blank !== 1'b1 && k < 20) begin
      @(negedge pclk);
      k++;
    end
    chk(blank, 1'b1, "blank start");
    while (blank === 1'b1 && n <= `RMST_BLANK_CYC) begin
      @(negedge pclk);
      n++;
    end
    chk(n <= `RMST_BLANK_CYC, 1'b1, "blank too long");
    rdchk(`RMST_OFF_CTRL, 32'h1, 32'h0, "run self clear");
    rdchk(`RMST_OFF_STATUS, 32'h4, 32'h0, "busy after run");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_powerup();
    int k;
    bo_stuck <= 5'h05; lo_stuck <= 2'h2; bu_stuck <= 5'h18; lu_stuck <= 2'h1;
    power_up_req <= 1;
    k = 0;
    do begin
      apb(0, `RMST_OFF_STATUS, 0);
      k++;
    end while (rd[`RMST_STAT_PUDONE_BIT] !== 1'b1 && k < 60);
    chk(rd[`RMST_STAT_PUDONE_BIT], 1'b1, "power-up test done");
    @(negedge pclk);
    chk(sw_en, 1'b1, "power-up continues");
    res_chk(32'h05, 32'h2, 32'h18, 32'h1);
    $display("power-up test done");
  endtask

  task t_ondemand();
    int n;
    bo_stuck <= 5'h12; lo_stuck <= 2'h0; bu_stuck <= 5'h00; lu_stuck <= 2'h2;
    apb(1, `RMST_OFF_CTRL, 32'h1);
    run_wait(n);
    res_chk(32'h12, 32'h0, 32'h00, 32'h2);
    apb(1, `RMST_OFF_BUCK_OV, 32'h0);
    rdchk(`RMST_OFF_BUCK_OV, 32'h1F, 32'h0, "plain clear");
    apb(0, 12'hFF0, 0);
    chk(err, 1'b1, "unmapped err");
    $display("on-demand test done");
  endtask

  task t_secure();
    int n;
    apb(1, `RMST_OFF_CTRL, 32'h4);
    apb(1, `RMST_OFF_CTRL, 32'h5);
    repeat (10) @(posedge pclk);
    chk(blank, 1'b0, "plain run ignored");
    rdchk(`RMST_OFF_STATUS, 32'h4, 32'h0, "not busy");
    apb(1, `RMST_OFF_SECURE_KEY, `RMST_SECURE_KEY);
    apb(1, `RMST_OFF_CTRL, 32'h5);
    run_wait(n);
    apb(1, `RMST_OFF_BUCK_OV, 32'h0);
    rdchk(`RMST_OFF_BUCK_OV, 32'h1F, 32'h12, "plain clear ignored");
    apb(1, `RMST_OFF_SECURE_KEY, `RMST_SECURE_KEY);
    apb(1, `RMST_OFF_BUCK_OV, 32'h0);
    rdchk(`RMST_OFF_BUCK_OV, 32'h1F, 32'h0, "secure clear");
    apb(1, `RMST_OFF_SECURE_KEY, `RMST_SECURE_KEY);
    apb(1, `RMST_OFF_CTRL, 32'h0);
    $display("secure test done");
  endtask

  task t_refs();
    apb(1, `RMST_OFF_CTRL, 32'h2);
    ref_mismatch <= 1;
    repeat (6) @(posedge pclk);
    chk({irq, shut, sw_en}, 3'b101, "bypass 1 irq only");
    rdchk(`RMST_OFF_STATUS, 32'h3, 32'h3, "status out of range");
    ref_mismatch <= 0;
    repeat (6) @(posedge pclk);
    apb(1, `RMST_OFF_STATUS, 32'h2);
    rdchk(`RMST_OFF_STATUS, 32'h3, 32'h0, "status in range");
    apb(1, `RMST_OFF_IRQ_MASK, 32'h1);
    ref_mismatch <= 1;
    repeat (6) @(posedge pclk);
    chk(irq, 1'b0, "masked irq");
    ref_mismatch <= 0;
    apb(1, `RMST_OFF_IRQ_MASK, 32'h0);
    apb(1, `RMST_OFF_CTRL, 32'h0);
    ref_mismatch <= 1;
    repeat (6) @(posedge pclk);
    chk({shut, sw_en}, 2'b10, "bypass 0 shutdown");
    $display("reference test done");
  endtask

  // Second reset: mismatch during power-up blocks even with bypass 1
  task t_block();
    presetn <= 0; power_up_req <= 0; safety_variant <= 1;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(1, `RMST_OFF_CTRL, 32'h2);
    power_up_req <= 1;
    repeat (80) @(posedge pclk);
    chk(sw_en, 1'b0, "power-up blocked");
    rdchk(`RMST_OFF_STATUS, 32'h8, 32'h8, "blocked flag");
    $display("block test done");
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk);
    chk({sw_en, shut, irq, blank}, 4'h0, "outputs after reset");
    rdchk(`RMST_OFF_CTRL, 32'hFFFFFFFF, `RMST_CTRL_RST, "ctrl reset");
    rdchk(`RMST_OFF_IRQ_MASK, 32'h1, 32'h0, "mask reset");
    t_powerup();
    t_ondemand();
    t_secure();
    t_refs();
    t_block();
    end_sim();
  end
endmodule
